// file: verilog/fdtf_core.sv
// Overview of operation
// - format writes host ID bytes, leading each with our ID mark
// - two CRC bytes end each formatted ID field
// - formatted data fields hold E5 followed by their CRC
// - format record-length code is coded like read commands
// - gaps other than gap 4 end in six 00 bytes, rest FF; counts give FF bytes
// - gap 2 is 11 FF bytes then 6 zero bytes
// - gap 4 FF bytes run until the index leading edge
// - gap 5 count of zero drops the index mark
// - mini track has no gap 5, no index mark, fewer sectors
// - bad-track registers add a step to cross a bad track
// - Read ID sends N ID fields from index in physical order
// - Read ID checks but does not send CRC bytes
// - data commands check drive, seek, then load the head
// - data commands read IDs to find track and sector
// - end sets interrupt request and outcome code
// - CRC error stops multisector, keeps failing sector number
// - write fetches sector bytes one by one by DMA per sector
// - result phase and interrupt follow, no host help between
// - length code 000..111 selects 128 to 16384 bytes
// - CRC x16+x12+x5+1, preset ones, mark included, MSB first
`timescale 1ns/1ps
`default_nettype none
module fdtf_core #(
  parameter int STEP_RATE_CYC = fdtf_pkg::STEP_RATE_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CMD_START,
  input wire logic [1:0] CMD_SEL,
  input wire logic [5:0] CMD_OPCODE,
  input wire logic [7:0] CMD_PAR0,
  input wire logic [7:0] CMD_PAR1,
  input wire logic [7:0] CMD_PAR2,
  input wire logic [7:0] CMD_PAR3,
  input wire logic [7:0] CMD_PAR4,
  input wire logic [7:0] BAD_TRACK0,
  input wire logic [7:0] BAD_TRACK1,
  input wire logic INT_CLR,
  input wire logic DRV_READY,
  input wire logic WR_PROTECT,
  input wire logic INDEX,
  input wire logic WR_BYTE_REQ,
  input wire logic RD_VALID,
  input wire logic RD_MARK,
  input wire logic [7:0] RD_DATA,
  input wire logic DMA_ACK,
  input wire logic [7:0] DMA_WDATA,
  output logic BUSY,
  output logic INT_REQ,
  output logic [7:0] RESULT,
  output logic [7:0] FAIL_SECTOR,
  output logic [1:0] DRV_SEL,
  output logic STEP,
  output logic STEP_IN,
  output logic HEAD_LOAD,
  output logic WR_GATE,
  output logic WR_MARK,
  output logic [7:0] WR_DATA,
  output logic DMA_REQ,
  output logic DMA_TO_MEM,
  output logic [7:0] DMA_RDATA
);
  typedef enum logic [4:0] {
    S_IDLE, S_SEEK, S_STEP, S_STEP_WAIT, S_IDX_WAIT, S_GAP, S_MARK,
    S_IDBYTE, S_DATA, S_CRC, S_GAP4, S_FIND_ID, S_RD_ID, S_FIND_DAM,
    S_RD_DATA, S_SKIP, S_DONE
  } fdtf_state_t;
  typedef enum logic [1:0] {M_IDX, M_ID, M_DAT, M_END} fdtf_mark_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ fdtf_pkg::CRC_POLY)
                          : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [19:0] sec_bytes(input logic [2:0] code);
    return fdtf_pkg::SECTOR_BASE << code;
  endfunction

  // logical to physical track: each bad track at or below shifts by one
  function automatic logic [7:0] phys_trk(input logic [7:0] t,
                                          input logic [7:0] b0,
                                          input logic [7:0] b1);
    logic [7:0] p;
    p = t;
    if (b0 != fdtf_pkg::NO_BAD_TRACK && p >= b0) p = p + 8'h01;
    if (b1 != fdtf_pkg::NO_BAD_TRACK && p >= b1) p = p + 8'h01;
    return p;
  endfunction

  fdtf_state_t state;
  fdtf_mark_t mk;
  logic [19:0] cnt;
  logic [19:0] dma_left;
  logic [5:0] op;
  logic [7:0] trk, sec, nsec, gap3, gap5, gap1, cur_trk, dbuf, res;
  logic [2:0] szc;
  logic [15:0] crc;
  logic [7:0] idb [4];
  logic [1:0] idx_seen;
  logic dfull, idx_d;

  wire idx_rise = INDEX & ~idx_d;
  wire is_fmt = op == fdtf_pkg::OP_FORMAT;
  wire is_rid = op == fdtf_pkg::OP_READ_ID;
  wire is_wr = op[fdtf_pkg::OPB_WR] & ~op[fdtf_pkg::OPB_RD];
  wire is_vf = op[fdtf_pkg::OPB_WR] & op[fdtf_pkg::OPB_RD];
  wire [5:0] c_op = CMD_OPCODE;
  wire c_fmt = c_op == fdtf_pkg::OP_FORMAT;
  wire c_rid = c_op == fdtf_pkg::OP_READ_ID;
  wire c_rw = ~c_op[5] & c_op[1] & (c_op[4] | c_op[3])
              & ~(c_op[4] & c_op[3] & ~c_op[2]);
  wire c_wr = c_op[3] & ~c_op[4];
  wire c_multi = c_op[fdtf_pkg::OPB_MULTI] | c_fmt;
  // single-record form is one 128-byte sector
  wire [2:0] c_szc = c_multi ? CMD_PAR2[7:5] : 3'h0;
  wire [7:0] c_nsec = c_rid ? CMD_PAR2
                    : (c_multi ? {3'h0, CMD_PAR2[4:0]} : 8'h01);
  wire [19:0] c_dma = c_fmt ? {10'h000, c_nsec, 2'h0}
                    : (c_wr ? 20'(sec_bytes(c_szc) * c_nsec) : 20'h00000);
  wire [7:0] tgt = phys_trk(trk, BAD_TRACK0, BAD_TRACK1);
  wire [15:0] rd_crc = crc_byte(crc, RD_DATA);
  wire [1:0] id_ix = 2'(3'h6 - cnt[2:0]);
  wire id_hit = idb[0] == trk && idb[2] == sec;
  wire wr_src_ok = is_fmt ? (state != S_DATA) : 1'b1;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= S_IDLE;
      mk <= M_IDX;
      cnt <= 20'h00000;
      dma_left <= 20'h00000;
      op <= 6'h00;
      trk <= 8'h00;
      sec <= 8'h00;
      nsec <= 8'h00;
      gap3 <= 8'h00;
      gap5 <= 8'h00;
      gap1 <= 8'h00;
      cur_trk <= 8'h00;
      dbuf <= 8'h00;
      res <= 8'h00;
      szc <= 3'h0;
      crc <= 16'h0000;
      idb <= '{4{8'h00}};
      idx_seen <= 2'h0;
      dfull <= 1'b0;
      idx_d <= 1'b0;
      BUSY <= 1'b0;
      INT_REQ <= 1'b0;
      RESULT <= 8'h00;
      FAIL_SECTOR <= 8'h00;
      DRV_SEL <= 2'h0;
      STEP <= 1'b0;
      STEP_IN <= 1'b0;
      HEAD_LOAD <= 1'b0;
      WR_GATE <= 1'b0;
      WR_MARK <= 1'b0;
      WR_DATA <= 8'h00;
      DMA_REQ <= 1'b0;
      DMA_TO_MEM <= 1'b0;
      DMA_RDATA <= 8'h00;
    end else begin
      idx_d <= INDEX;
      // an interrupt raised in the same cycle as the clear survives
      if (INT_CLR) INT_REQ <= 1'b0;
      if (WR_BYTE_REQ) WR_MARK <= 1'b0;
      // memory-to-disk bytes are prefetched one deep
      if (DMA_REQ && DMA_ACK) begin
        DMA_REQ <= 1'b0;
        if (!DMA_TO_MEM) begin
          dbuf <= DMA_WDATA;
          dfull <= 1'b1;
          dma_left <= dma_left - 20'h00001;
        end
      end else if (BUSY && !DMA_TO_MEM && !DMA_REQ && !dfull
                   && dma_left != 20'h00000) begin
        DMA_REQ <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          if (CMD_START) begin
            op <= c_op;
            DRV_SEL <= CMD_SEL;
            trk <= CMD_PAR0;
            sec <= CMD_PAR1;
            gap3 <= CMD_PAR1;
            gap5 <= CMD_PAR3;
            gap1 <= CMD_PAR4;
            szc <= c_szc;
            nsec <= c_nsec;
            dma_left <= c_dma;
            dfull <= 1'b0;
            DMA_TO_MEM <= c_rid | (c_op[4] & ~c_op[3]);
            BUSY <= 1'b1;
            if (!(c_fmt | c_rid | c_rw)) begin
              res <= fdtf_pkg::RES_BAD_CMD;
              state <= S_DONE;
            end else begin
              state <= S_SEEK;
            end
          end
        end
        S_SEEK: begin
          if (!DRV_READY) begin
            res <= fdtf_pkg::RES_NOT_READY;
            state <= S_DONE;
          end else if ((is_fmt | is_wr) && WR_PROTECT) begin
            res <= fdtf_pkg::RES_PROTECTED;
            state <= S_DONE;
          end else if (cur_trk == tgt) begin
            HEAD_LOAD <= 1'b1;
            idx_seen <= 2'h0;
            state <= (is_fmt | is_rid) ? S_IDX_WAIT : S_FIND_ID;
          end else begin
            STEP <= 1'b1;
            STEP_IN <= tgt > cur_trk;
            cnt <= 20'(fdtf_pkg::STEP_PULSE_CYC);
            state <= S_STEP;
          end
        end
        S_STEP: begin
          cnt <= cnt - 20'h00001;
          if (cnt == 20'h00001) begin
            STEP <= 1'b0;
            cur_trk <= STEP_IN ? cur_trk + 8'h01 : cur_trk - 8'h01;
            cnt <= 20'(STEP_RATE_CYC);
            state <= S_STEP_WAIT;
          end
        end
        S_STEP_WAIT: begin
          cnt <= cnt - 20'h00001;
          if (cnt == 20'h00001) state <= S_SEEK;
        end
        S_IDX_WAIT: begin
          if (idx_rise) begin
            if (is_rid) begin
              state <= S_FIND_ID;
            end else begin
              WR_GATE <= 1'b1;
              state <= S_GAP;
              // a zero gap 5 (mini track) skips gap 5 and the index mark
              if (gap5 != 8'h00) begin
                cnt <= {12'h000, gap5} + fdtf_pkg::SYNC_LEN;
                mk <= M_IDX;
              end else begin
                cnt <= {12'h000, gap1} + fdtf_pkg::SYNC_LEN;
                mk <= M_ID;
              end
            end
          end
        end
        S_GAP: if (WR_BYTE_REQ) begin
          WR_DATA <= (cnt > fdtf_pkg::SYNC_LEN) ? fdtf_pkg::BYTE_GAP
                                                 : fdtf_pkg::BYTE_SYNC;
          cnt <= cnt - 20'h00001;
          if (cnt == 20'h00001) state <= (mk == M_END) ? S_GAP4 : S_MARK;
        end
        S_MARK: if (WR_BYTE_REQ) begin
          WR_MARK <= 1'b1;
          case (mk)
            M_IDX: begin
              WR_DATA <= fdtf_pkg::AM_INDEX;
              cnt <= {12'h000, gap1} + fdtf_pkg::SYNC_LEN;
              mk <= M_ID;
              state <= S_GAP;
            end
            M_ID: begin
              WR_DATA <= fdtf_pkg::AM_ID;
              crc <= crc_byte(fdtf_pkg::CRC_INIT, fdtf_pkg::AM_ID);
              cnt <= fdtf_pkg::ID_BYTES;
              state <= S_IDBYTE;
            end
            default: begin
              WR_DATA <= op[fdtf_pkg::OPB_DEL] ? fdtf_pkg::AM_DELETED
                                               : fdtf_pkg::AM_DATA;
              crc <= crc_byte(fdtf_pkg::CRC_INIT,
                              op[fdtf_pkg::OPB_DEL] ? fdtf_pkg::AM_DELETED
                                                    : fdtf_pkg::AM_DATA);
              cnt <= sec_bytes(szc);
              state <= S_DATA;
            end
          endcase
        end
        S_IDBYTE, S_DATA: if (WR_BYTE_REQ) begin
          if (wr_src_ok && !dfull) begin
            // the serializer outran DMA; the field would be corrupt
            res <= fdtf_pkg::RES_LATE_DMA;
            WR_GATE <= 1'b0;
            state <= S_DONE;
          end else begin
            WR_DATA <= wr_src_ok ? dbuf : fdtf_pkg::BYTE_FILL;
            crc <= crc_byte(crc, wr_src_ok ? dbuf
                                           : fdtf_pkg::BYTE_FILL);
            dfull <= dfull & ~wr_src_ok;
            cnt <= cnt - 20'h00001;
            if (cnt == 20'h00001) begin
              cnt <= is_wr ? fdtf_pkg::CRC_LEN + 20'h00001
                           : fdtf_pkg::CRC_LEN;
              state <= S_CRC;
            end
          end
        end
        S_CRC: if (WR_BYTE_REQ) begin
          // a write sends one trailing byte so the gate drops after CRC
          WR_DATA <= crc[15:8];
          crc <= {crc[7:0], 8'h00};
          cnt <= cnt - 20'h00001;
          if (cnt == 20'h00001) begin
            if (mk == M_ID) begin
              cnt <= fdtf_pkg::GAP2_LEN;
              mk <= M_DAT;
              state <= S_GAP;
            end else if (is_fmt) begin
              nsec <= nsec - 8'h01;
              cnt <= {12'h000, gap3} + fdtf_pkg::SYNC_LEN;
              mk <= (nsec == 8'h01) ? M_END : M_ID;
              state <= S_GAP;
            end else begin
              WR_GATE <= 1'b0;
              idx_seen <= 2'h0;
              nsec <= nsec - 8'h01;
              sec <= sec + 8'h01;
              state <= (nsec == 8'h01) ? S_DONE : S_FIND_ID;
            end
          end
        end
        S_GAP4: begin
          if (WR_BYTE_REQ) WR_DATA <= fdtf_pkg::BYTE_GAP;
          if (idx_rise) begin
            WR_GATE <= 1'b0;
            state <= S_DONE;
          end
        end
        S_FIND_ID: begin
          if (idx_rise) begin
            idx_seen <= idx_seen + 2'h1;
            if (idx_seen == 2'h1) begin
              res <= fdtf_pkg::RES_NOT_FOUND;
              state <= S_DONE;
            end
          end else if (RD_VALID && RD_MARK && RD_DATA == fdtf_pkg::AM_ID) begin
            crc <= crc_byte(fdtf_pkg::CRC_INIT, RD_DATA);
            cnt <= fdtf_pkg::ID_READ_LEN;
            state <= S_RD_ID;
          end
        end
        S_RD_ID: if (RD_VALID) begin
          crc <= rd_crc;
          cnt <= cnt - 20'h00001;
          if (cnt > fdtf_pkg::CRC_LEN) begin
            idb[id_ix] <= RD_DATA;
            if (is_rid) begin
              DMA_RDATA <= RD_DATA;
              DMA_REQ <= 1'b1;
              if (DMA_REQ) begin
                res <= fdtf_pkg::RES_LATE_DMA;
                state <= S_DONE;
              end
            end
          end else if (cnt == 20'h00001) begin
            if (rd_crc != 16'h0000) begin
              res <= fdtf_pkg::RES_ID_CRC;
              FAIL_SECTOR <= sec;
              state <= S_DONE;
            end else if (is_rid) begin
              nsec <= nsec - 8'h01;
              state <= (nsec == 8'h01) ? S_DONE : S_FIND_ID;
            end else if (id_hit && is_wr) begin
              cnt <= fdtf_pkg::GAP2_FF;
              state <= S_SKIP;
            end else begin
              state <= id_hit ? S_FIND_DAM : S_FIND_ID;
            end
          end
        end
        S_SKIP: if (WR_BYTE_REQ) begin
          cnt <= cnt - 20'h00001;
          if (cnt == 20'h00001) begin
            WR_GATE <= 1'b1;
            cnt <= fdtf_pkg::SYNC_LEN;
            mk <= M_DAT;
            state <= S_GAP;
          end
        end
        S_FIND_DAM: if (RD_VALID && RD_MARK) begin
          if (RD_DATA == fdtf_pkg::AM_DATA
              || RD_DATA == fdtf_pkg::AM_DELETED) begin
            if (RD_DATA == fdtf_pkg::AM_DELETED) res <= fdtf_pkg::RES_DELETED;
            crc <= crc_byte(fdtf_pkg::CRC_INIT, RD_DATA);
            cnt <= sec_bytes(szc) + fdtf_pkg::CRC_LEN;
            state <= S_RD_DATA;
          end else begin
            res <= fdtf_pkg::RES_NOT_FOUND;
            state <= S_DONE;
          end
        end
        S_RD_DATA: if (RD_VALID) begin
          crc <= rd_crc;
          cnt <= cnt - 20'h00001;
          if (cnt > fdtf_pkg::CRC_LEN && !is_vf) begin
            DMA_RDATA <= RD_DATA;
            DMA_REQ <= 1'b1;
            if (DMA_REQ) begin
              res <= fdtf_pkg::RES_LATE_DMA;
              state <= S_DONE;
            end
          end else if (cnt == 20'h00001) begin
            idx_seen <= 2'h0;
            if (rd_crc != 16'h0000) begin
              res <= fdtf_pkg::RES_DATA_CRC;
              FAIL_SECTOR <= sec;
              state <= S_DONE;
            end else begin
              nsec <= nsec - 8'h01;
              sec <= sec + 8'h01;
              state <= (nsec == 8'h01) ? S_DONE : S_FIND_ID;
            end
          end
        end
        S_DONE: begin
          WR_GATE <= 1'b0;
          dma_left <= 20'h00000;
          if (!DMA_TO_MEM) DMA_REQ <= 1'b0;
          // the last byte bound for memory must be taken before we report
          if (!DMA_REQ || !DMA_TO_MEM) begin
            INT_REQ <= 1'b1;
            RESULT <= res;
            BUSY <= 1'b0;
            res <= fdtf_pkg::RES_OK;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_id_mark_lead: assert property (
    state == S_MARK && mk == M_ID && WR_BYTE_REQ
    |=> WR_DATA == fdtf_pkg::AM_ID && WR_MARK && state == S_IDBYTE)
    else $error("ID field not led by ID mark");
  a_fill_pattern: assert property (
    state == S_DATA && is_fmt && WR_BYTE_REQ
    |=> WR_DATA == fdtf_pkg::BYTE_FILL)
    else $error("format data byte is not fill pattern");
  a_gap_bytes: assert property (
    state == S_GAP && WR_BYTE_REQ
    |=> WR_DATA == (($past(cnt) > fdtf_pkg::SYNC_LEN)
                    ? fdtf_pkg::BYTE_GAP : fdtf_pkg::BYTE_SYNC))
    else $error("gap byte value wrong");
  a_gap2_len: assert property (
    state == S_CRC && mk == M_ID && WR_BYTE_REQ && cnt == 20'h00001
    |=> state == S_GAP && cnt == 20'h00011 && mk == M_DAT)
    else $error("gap 2 not 17 bytes");
  a_gap4_stop: assert property (
    state == S_GAP4 && idx_rise |=> !WR_GATE && state == S_DONE)
    else $error("gap 4 not ended by index");
  a_no_index_mark: assert property (
    state == S_IDX_WAIT && is_fmt && idx_rise && gap5 == 8'h00
    |=> mk == M_ID && state == S_GAP)
    else $error("index mark kept with zero gap 5");
  a_crc_hidden: assert property (
    state == S_RD_ID && RD_VALID && cnt <= fdtf_pkg::CRC_LEN
    |=> DMA_REQ == $past(DMA_REQ && !DMA_ACK))
    else $error("ID CRC byte sent to memory");
  a_fail_sector: assert property (
    state == S_RD_DATA && RD_VALID && cnt == 20'h00001
    && rd_crc != 16'h0000
    |=> FAIL_SECTOR == $past(sec) && state == S_DONE)
    else $error("failing sector not kept");
  a_result_irq: assert property (
    state == S_DONE && !(DMA_REQ && DMA_TO_MEM)
    |=> state == S_IDLE && INT_REQ && !BUSY && RESULT == $past(res))
    else $error("no interrupt at end of command");
  a_step_seek: assert property (
    state == S_SEEK && !DRV_READY |=> state == S_DONE && !STEP)
    else $error("seek on a drive that is not ready");

  c_format_end: cover property (state == S_GAP4 && idx_rise);
  c_read_id_end: cover property (is_rid && state == S_DONE);
  c_write_crc: cover property (is_wr && state == S_CRC && WR_BYTE_REQ);
  c_data_crc_err: cover property (state == S_DONE
                                  && res == fdtf_pkg::RES_DATA_CRC);
endmodule
`default_nettype wire

// file: verilog/fdtf_pkg.sv
`default_nettype none
package fdtf_pkg;
  // command opcodes, six bits below the two drive-select bits
  localparam logic [5:0] OP_FORMAT = 6'h23;
  localparam logic [5:0] OP_READ_ID = 6'h1B;
  localparam int OPB_MULTI = 0;
  localparam int OPB_DEL = 2;
  localparam int OPB_WR = 3;
  localparam int OPB_RD = 4;
  // bytes on the track
  localparam logic [7:0] BYTE_GAP = 8'hFF;
  localparam logic [7:0] BYTE_SYNC = 8'h00;
  localparam logic [7:0] BYTE_FILL = 8'hE5;
  localparam logic [7:0] AM_INDEX = 8'hFC;
  localparam logic [7:0] AM_ID = 8'hFE;
  localparam logic [7:0] AM_DATA = 8'hFB;
  localparam logic [7:0] AM_DELETED = 8'hF8;
  localparam logic [19:0] SYNC_LEN = 20'h00006;
  localparam logic [19:0] GAP2_FF = 20'h0000B;
  localparam logic [19:0] GAP2_LEN = GAP2_FF + SYNC_LEN;
  localparam logic [19:0] ID_BYTES = 20'h00004;
  localparam logic [19:0] ID_READ_LEN = 20'h00006;
  localparam logic [19:0] CRC_LEN = 20'h00002;
  localparam logic [19:0] SECTOR_BASE = 20'h00080;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [7:0] NO_BAD_TRACK = 8'hFF;
  // outcome codes
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_BAD_CMD = 8'h04;
  localparam logic [7:0] RES_LATE_DMA = 8'h08;
  localparam logic [7:0] RES_ID_CRC = 8'h0C;
  localparam logic [7:0] RES_DATA_CRC = 8'h0E;
  localparam logic [7:0] RES_NOT_READY = 8'h10;
  localparam logic [7:0] RES_PROTECTED = 8'h12;
  localparam logic [7:0] RES_NOT_FOUND = 8'h18;
  localparam logic [7:0] RES_DELETED = 8'h20;
  // timing
  localparam int CLK_NS = 50;
  localparam int STEP_PULSE_NS = 2000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_RATE_US = 6000;
  localparam int STEP_RATE_CYC = STEP_RATE_US * 1000 / CLK_NS;
endpackage
`default_nettype wire

// file: tb/fdtf_tb_pkg.sv
`default_nettype none
package fdtf_tb_pkg;
  // one byte through the x16+x12+x5+1 divider, msb first
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
    end
    return r;
  endfunction
  function automatic logic [7:0] sec_byte(int s, int i);
    return 8'(s * 29 + i);
  endfunction
endpackage
`default_nettype wire

// file: tb/fdtf_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdtf_drive_model (
  input wire logic clk,
  input wire logic step,
  input wire logic step_in,
  input wire logic dma_req,
  input wire logic dma_to_mem,
  input wire logic [7:0] bad_trk,
  input wire logic [7:0] bad_sec,
  output logic index,
  output logic wr_byte_req,
  output logic rd_valid,
  output logic rd_mark,
  output logic [7:0] rd_data,
  output logic dma_ack,
  output logic [7:0] dma_wdata
);
  logic [7:0] q[$];
  logic [7:0] f[$];
  logic [7:0] trk = 8'h00;
  logic [7:0] lt;
  logic step_d = 1'b0;
  logic [2:0] cnt = 3'h0;
  // tracks past a bad one carry the logical number one lower
  assign lt = trk - ((trk > bad_trk) ? 8'h01 : 8'h00);
  task automatic push(logic [7:0] b);
    q.push_back(b);
  endtask
  task automatic send(logic [7:0] b, logic m);
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_data <= b;
    rd_mark <= m;
    @(posedge clk);
    rd_valid <= 1'b0;
    rd_mark <= 1'b0;
    rd_data <= ~b;
    repeat (6) @(posedge clk);
  endtask
  task automatic field(logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = fdtf_tb_pkg::crc_step(c, f[i]);
      send(f[i], i == 0);
    end
    if (bad) c = ~c;
    send(c[15:8], 1'b0);
    send(c[7:0], 1'b0);
  endtask
  always @(posedge clk) begin
    cnt <= cnt + 3'h1;
    wr_byte_req <= cnt == 3'h0;
    step_d <= step;
    if (step && !step_d) trk <= step_in ? trk + 8'h01 : trk - 8'h01;
    dma_ack <= dma_req && !dma_ack;
    if (dma_req && !dma_ack && !dma_to_mem && q.size() > 0)
      dma_wdata <= q.pop_front();
    else if (dma_ack)
      dma_wdata <= ~dma_wdata;
  end
  initial begin
    {index, rd_valid, rd_mark} = 3'h0;
    rd_data = 8'h00;
    forever begin
      repeat (1500) @(posedge clk);
      index <= 1'b1;
      repeat (10) @(posedge clk);
      index <= 1'b0;
      for (int s = 1; s <= 3; s++) begin
        f = {8'hFE, lt, 8'h00, 8'(s), 8'h00};
        field(1'b0);
        f = {8'hFB};
        for (int i = 0; i < 128; i++)
          f.push_back(fdtf_tb_pkg::sec_byte(s, i));
        field(8'(s) == bad_sec);
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/floppy_track_format_and_transfer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module floppy_track_format_and_transfer_tb;
  logic SYS_CLK = 1'b0, RST_B = 1'b0, CMD_START = 1'b0, INT_CLR = 1'b0;
  logic [1:0] CMD_SEL = 2'h0, DRV_SEL;
  logic [5:0] CMD_OPCODE = 6'h00;
  logic [7:0] CMD_PAR0 = 8'h00, CMD_PAR1 = 8'h00, CMD_PAR2 = 8'h00;
  logic [7:0] CMD_PAR3 = 8'h00, CMD_PAR4 = 8'h00, bad_sec = 8'h00;
  logic [7:0] BAD_TRACK0 = 8'hFF, BAD_TRACK1 = 8'hFF;
  logic DRV_READY = 1'b1, WR_PROTECT = 1'b0;
  logic INDEX, WR_BYTE_REQ, RD_VALID, RD_MARK, DMA_ACK, DMA_REQ, DMA_TO_MEM;
  logic BUSY, INT_REQ, STEP, STEP_IN, HEAD_LOAD, WR_GATE, WR_MARK;
  logic [7:0] RD_DATA, DMA_WDATA, RESULT, FAIL_SECTOR, WR_DATA, DMA_RDATA;
  logic req_d = 1'b0, gate_d = 1'b0, step_d = 1'b0;
  logic [7:0] wr_q[$], mem_q[$], exp_q[$];
  int failures = 0, tests_run = 0, steps = 0, marks = 0;
  fdtf_core #(.STEP_RATE_CYC(4)) dut_u (.*);
  fdtf_drive_model drv_u (.clk(SYS_CLK), .step(STEP), .step_in(STEP_IN),
    .dma_req(DMA_REQ), .dma_to_mem(DMA_TO_MEM), .bad_trk(BAD_TRACK0),
    .bad_sec(bad_sec), .index(INDEX), .wr_byte_req(WR_BYTE_REQ),
    .rd_valid(RD_VALID), .rd_mark(RD_MARK), .rd_data(RD_DATA),
    .dma_ack(DMA_ACK), .dma_wdata(DMA_WDATA));
  initial forever #25 SYS_CLK = ~SYS_CLK;
  // a byte counts only if the gate was on when the serializer asked
  always @(posedge SYS_CLK) begin
    req_d <= WR_BYTE_REQ;
    gate_d <= WR_GATE;
    step_d <= STEP;
    if (req_d && gate_d) wr_q.push_back(WR_DATA);
    if (req_d && gate_d && WR_MARK) marks++;
    if (DMA_REQ && DMA_ACK && DMA_TO_MEM) mem_q.push_back(DMA_RDATA);
    if (STEP && !step_d) steps++;
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic void put(int n, logic [7:0] b);
    repeat (n) exp_q.push_back(b);
  endfunction
  function automatic void add_fld(logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = fdtf_tb_pkg::crc_step(c, f[i]);
      exp_q.push_back(f[i]);
    end
    put(1, c[15:8]);
    put(1, c[7:0]);
  endfunction
  task automatic cmd(logic [5:0] op, logic [7:0] p0, p1, p2, p3, p4, res);
    @(posedge SYS_CLK);
    CMD_START <= 1'b1;
    CMD_OPCODE <= op;
    CMD_SEL <= 2'($urandom);
    {CMD_PAR0, CMD_PAR1, CMD_PAR2, CMD_PAR3, CMD_PAR4} <= {p0, p1, p2, p3, p4};
    @(posedge SYS_CLK);
    CMD_START <= 1'b0;
    #1 chk(BUSY, 1);
    // step off the edge so BUSY is read after it settles
    for (int i = 0; i < 20000 && BUSY !== 1'b0; i++) @(posedge SYS_CLK) #1;
    #1 chk(RESULT, res);
    chk(BUSY, 0);
    chk(INT_REQ, 1);
    chk(DRV_SEL, CMD_SEL);
    @(posedge SYS_CLK);
    INT_CLR <= 1'b1;
    @(posedge SYS_CLK);
    INT_CLR <= 1'b0;
    #1 chk(INT_REQ, 0);
    $display("test with opcode %h done", op);
  endtask
  initial begin
    int unsigned seed_v;
    logic [7:0] g1, g3, g5;
    logic [7:0] f[$];
    seed_v = $urandom(32'hE709);
    repeat (10) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    @(posedge SYS_CLK);
    #1 chk({BUSY, INT_REQ, RESULT, WR_GATE, DMA_REQ}, 0);
    cmd(6'h3F, 0, 0, 0, 0, 0, fdtf_pkg::RES_BAD_CMD);
    DRV_READY <= 1'b0;
    cmd(6'h12, 0, 1, 0, 0, 0, fdtf_pkg::RES_NOT_READY);
    DRV_READY <= 1'b1;
    WR_PROTECT <= 1'b1;
    cmd(fdtf_pkg::OP_FORMAT, 0, 5, 1, 5, 5, fdtf_pkg::RES_PROTECTED);
    WR_PROTECT <= 1'b0;
    // first pass leaves out gap 5 and the index mark, as a mini track does
    for (int k = 0; k < 2; k++) begin
      g1 = 8'($urandom_range(1, 20));
      g3 = 8'($urandom_range(1, 20));
      g5 = k ? 8'($urandom_range(1, 20)) : 8'h00;
      f = {fdtf_pkg::AM_ID, 8'($urandom), 8'($urandom), 8'($urandom), 8'h00};
      for (int i = 1; i < 5; i++) drv_u.push(f[i]);
      exp_q = {};
      if (g5 != 0) begin
        put(g5, 8'hFF);
        put(6, 8'h00);
        put(1, fdtf_pkg::AM_INDEX);
      end
      put(g1, 8'hFF);
      put(6, 8'h00);
      add_fld(f);
      put(11, 8'hFF);
      put(6, 8'h00);
      f = {fdtf_pkg::AM_DATA};
      repeat (128) f.push_back(8'hE5);
      add_fld(f);
      put(g3, 8'hFF);
      put(6, 8'h00);
      wr_q = {};
      cmd(fdtf_pkg::OP_FORMAT, 0, g3, 8'h01, g5, g1,
          fdtf_pkg::RES_OK);
      foreach (exp_q[i]) chk(wr_q[i], exp_q[i]);
      chk(wr_q.size() > exp_q.size(), 1);
      for (int i = exp_q.size(); i < wr_q.size(); i++)
        chk(wr_q[i], 8'hFF);
      chk(marks, k ? 5 : 2);
    end
    mem_q = {};
    cmd(fdtf_pkg::OP_READ_ID, 0, 0, 2, 0, 0, fdtf_pkg::RES_OK);
    chk(mem_q.size(), 8);
    foreach (mem_q[i]) chk(mem_q[i], i % 4 == 2 ? i / 4 + 1 : 0);
    bad_sec <= 8'h02;
    mem_q = {};
    cmd(6'h13, 0, 1, 8'h03, 0, 0, fdtf_pkg::RES_DATA_CRC);
    chk(FAIL_SECTOR, 2);
    chk(mem_q.size() <= 256, 1);
    for (int i = 0; i < 128; i++)
      chk(mem_q[i], fdtf_tb_pkg::sec_byte(1, i));
    bad_sec <= 8'h03;
    mem_q = {};
    cmd(6'h1F, 0, 1, 8'h03, 0, 0, fdtf_pkg::RES_DATA_CRC);
    chk(FAIL_SECTOR, 3);
    chk(mem_q.size(), 0);
    bad_sec <= 8'h00;
    cmd(6'h12, 0, 9, 0, 0, 0, fdtf_pkg::RES_NOT_FOUND);
    for (int i = 0; i < 128; i++) drv_u.push(fdtf_tb_pkg::sec_byte(7, i));
    exp_q = {};
    put(6, 8'h00);
    f = {fdtf_pkg::AM_DATA};
    for (int i = 0; i < 128; i++) f.push_back(fdtf_tb_pkg::sec_byte(7, i));
    add_fld(f);
    put(1, 8'h00);
    wr_q = {};
    cmd(6'h0A, 0, 1, 0, 0, 0, fdtf_pkg::RES_OK);
    foreach (exp_q[i]) chk(wr_q[i], exp_q[i]);
    chk(wr_q.size(), exp_q.size());
    chk(marks, 6);
    BAD_TRACK0 <= 8'h01;
    steps = 0;
    mem_q = {};
    cmd(6'h12, 2, 1, 0, 0, 0, fdtf_pkg::RES_OK);
    chk(steps, 3);
    chk(HEAD_LOAD, 1);
    chk(STEP_IN, 1);
    for (int i = 0; i < 128; i++)
      chk(mem_q[i], fdtf_tb_pkg::sec_byte(1, i));
    give_verdict;
  end
  initial begin
    repeat (99000) @(posedge SYS_CLK);
    failures++;
    give_verdict;
  end
endmodule
`default_nettype wire
